// [logic/b4sp_mem.sv]
// Purpose: Word storage with a masked write port and a registered read port.
// Assumes: One write and one read per cycle at most.
// Notes:   A read of the word being written returns the new bits, which keeps a
//          read right behind a write coherent without extra pipeline stages.
`timescale 1ns/100ps
module b4sp_mem
  import b4sp_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rst_b,
  b4sp_mem_if.mem    mif
);

  logic [DATA_W-1:0] store [2**MEM_AW];
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;
  logic [DATA_W-1:0] merged;

  // Merge the lanes being written over the stored word; forward when addresses meet.
  always_comb begin
    merged = (store[mif.wr_addr] & ~mif.wr_mask) | (mif.wr_data & mif.wr_mask);
    rd_data_next = rd_data_reg;
    if (mif.rd_en) begin
      if (mif.wr_en && (mif.wr_addr == mif.rd_addr)) begin
        rd_data_next = merged;
      end else begin
        rd_data_next = store[mif.rd_addr];
      end
    end
  end

  // The array itself has no reset; only the read register does.
  always_ff @(posedge ref_clk) begin
    if (mif.wr_en) begin
      store[mif.wr_addr] <= merged;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_reg <= DATA_RST;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign mif.rd_data = rd_data_reg;

  default clocking mc @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_fwd_full_word: assert property (
    mif.rd_en && mif.wr_en && (mif.wr_addr == mif.rd_addr) && (&mif.wr_mask)
    |=> mif.rd_data == $past(mif.wr_data))
    else $error("read beside a full write did not return the new word");

endmodule

// [logic/b4sp_port.sv]
// Purpose: Command and data logic of a burst-of-four SRAM with separate read and
//          write ports, sampling strobes and pins on one reference clock.
// Assumes: Strobe edges are far apart compared to the 20 ns reference period.
// Notes:   Every pin passes two flip-flops, so all inputs keep their relative timing.
`timescale 1ns/100ps
module b4sp_port
  import b4sp_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              main_strobe,
  input  wire logic              main_strobe_comp,
  input  wire logic              out_strobe,
  input  wire logic              out_strobe_comp,
  input  wire logic              loop_disable_n,
  input  wire logic              org_nibble,
  input  wire logic              read_port_select_n,
  input  wire logic              write_port_select_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] write_data,
  input  wire logic [1:0]        lane_write_select_n,
  input  wire logic [1:0]        nibble_lane_select_n,
  output logic      [DATA_W-1:0] read_data,
  output logic                   read_data_oe
);

  b4sp_mem_if mif ();

  b4sp_mem u_mem (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .mif     (mif)
  );

  logic [SYNC_W-1:0] sync1_reg, sync2_reg;
  logic [3:0]        prev_reg, prev_next;
  b4sp_last_e        last_reg, last_next;
  logic              wr_pend_reg, wr_pend_next, wr_act_reg, wr_act_next;
  logic [ADDR_W-1:0] wr_pend_addr_reg, wr_pend_addr_next, wr_addr_reg, wr_addr_next;
  logic [BEAT_W-1:0] wr_beat_reg, wr_beat_next, rd_beat_reg, rd_beat_next;
  logic              rdp_reg, rdp_next, go_reg, go_next, act_reg, act_next;
  logic [ADDR_W-1:0] rdp_addr_reg, rdp_addr_next, go_addr_reg, go_addr_next;
  logic [ADDR_W-1:0] rd_addr_reg, rd_addr_next;
  logic              launch_d_reg, out_evt_d_reg, single_reg, single_next;
  logic [1:0]        strap_cnt_reg, strap_cnt_next;
  logic [DATA_W-1:0] read_data_reg, read_data_next;
  logic              read_data_oe_reg, read_data_oe_next;

  logic              main_rise, comp_rise, out_main, out_comp, out_evt, dll_off;
  logic              rd_ok, wr_ok, rd_start, wr_start, wr_cap, launch, go_now;
  logic [ADDR_W-1:0] go_addr_now;
  logic [DATA_W-1:0] lane_mask;

  // Two-flop synchroniser for every pin; only the second stage is read.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else begin
      sync1_reg <= {nibble_lane_select_n, lane_write_select_n, write_data, addr,
                    write_port_select_n, read_port_select_n, org_nibble, loop_disable_n,
                    out_strobe_comp, out_strobe, main_strobe_comp, main_strobe};
      sync2_reg <= sync1_reg;
    end
  end

  // Strobe edges and the phase in which read beats leave the device.
  always_comb begin
    prev_next = sync2_reg[P_OCOMP:P_MAIN];
    main_rise = sync2_reg[P_MAIN] & ~prev_reg[P_MAIN];
    comp_rise = sync2_reg[P_COMP] & ~prev_reg[P_COMP];
    dll_off   = ~sync2_reg[P_LOOP];
    // Single-strobe or loop-off operation launches read data from the main pair.
    out_main  = (single_reg | dll_off) ? main_rise : (sync2_reg[P_OMAIN] & ~prev_reg[P_OMAIN]);
    out_comp  = (single_reg | dll_off) ? comp_rise : (sync2_reg[P_OCOMP] & ~prev_reg[P_OCOMP]);
    out_evt   = out_main | out_comp;
  end

  // Start decode, write beat capture and read beat launch.
  always_comb begin
    last_next = last_reg;
    wr_pend_next = wr_pend_reg;
    wr_pend_addr_next = wr_pend_addr_reg;
    wr_act_next = wr_act_reg;
    wr_addr_next = wr_addr_reg;
    wr_beat_next = wr_beat_reg;
    rdp_next = rdp_reg;
    rdp_addr_next = rdp_addr_reg;
    go_next = go_reg;
    go_addr_next = go_addr_reg;
    act_next = act_reg;
    rd_addr_next = rd_addr_reg;
    rd_beat_next = rd_beat_reg;
    // A select that started an operation on the previous main rise is don't-care now.
    rd_ok = ~sync2_reg[P_RPS] & (last_reg != LAST_RD);
    wr_ok = ~sync2_reg[P_WPS] & (last_reg != LAST_WR);
    rd_start = main_rise & rd_ok;
    wr_start = main_rise & wr_ok & ~rd_ok;
    if (main_rise) begin
      last_next = rd_start ? LAST_RD : (wr_start ? LAST_WR : LAST_NONE);
      wr_pend_next = wr_start;
      wr_pend_addr_next = sync2_reg[P_ADDR +: ADDR_W];
      rdp_next = rd_start;
      rdp_addr_next = sync2_reg[P_ADDR +: ADDR_W];
      go_next = rdp_reg;
      go_addr_next = rdp_addr_reg;
    end
    // Even write beats ride main rises, odd ones complementary rises.
    wr_cap = (main_rise & wr_pend_reg)
           | (wr_act_reg & (wr_beat_reg[0] ? comp_rise : main_rise));
    mif.wr_en = wr_cap;
    mif.wr_addr = (main_rise & wr_pend_reg) ? {wr_pend_addr_reg, BEAT_RST}
                                            : {wr_addr_reg, wr_beat_reg};
    mif.wr_data = sync2_reg[P_DATA +: DATA_W];
    if (main_rise & wr_pend_reg) begin
      wr_act_next = 1'b1;
      wr_beat_next = 2'h1;
      wr_addr_next = wr_pend_addr_reg;
    end else if (wr_cap) begin
      wr_beat_next = wr_beat_reg + 2'h1;
      wr_act_next = (wr_beat_reg != BEAT_LAST);
    end
    // With the loop off, beat zero goes out on the very rise that arms it.
    go_now = go_reg | (main_rise & rdp_reg & dll_off);
    go_addr_now = go_reg ? go_addr_reg : rdp_addr_reg;
    launch = 1'b0;
    mif.rd_addr = {rd_addr_reg, rd_beat_reg};
    // Beat n leaves on the complementary phase when n is even and the loop is on.
    if (act_reg && ((rd_beat_reg[0] ^ ~dll_off) ? out_comp : out_main)) begin
      launch = 1'b1;
      rd_beat_next = rd_beat_reg + 2'h1;
      act_next = (rd_beat_reg != BEAT_LAST);
    end else if (!act_reg && go_now && (dll_off ? out_main : out_comp)) begin
      launch = 1'b1;
      mif.rd_addr = {go_addr_now, BEAT_RST};
      act_next = 1'b1;
      rd_beat_next = 2'h1;
      rd_addr_next = go_addr_now;
      go_next = 1'b0;
    end
    mif.rd_en = launch;
  end

  // Lane masks of the two organisations; a high select keeps the stored lane.
  always_comb begin
    if (sync2_reg[P_ORG]) begin
      lane_mask = {10'h000, {NIB_W{~sync2_reg[P_NIB + 1]}},
                   {NIB_W{~sync2_reg[P_NIB]}}};
    end else begin
      lane_mask = {{BYTE_W{~sync2_reg[P_LANE + 1]}},
                   {BYTE_W{~sync2_reg[P_LANE]}}};
    end
    mif.wr_mask = lane_mask;
  end

  // Output stage and strap capture; outputs switch off on an event with no beat.
  always_comb begin
    read_data_next = read_data_reg;
    read_data_oe_next = read_data_oe_reg;
    if (out_evt_d_reg) begin
      read_data_oe_next = launch_d_reg;
      read_data_next = launch_d_reg ? mif.rd_data : read_data_reg;
    end
    strap_cnt_next = strap_cnt_reg;
    single_next = single_reg;
    // The strap is read once, after the synchroniser has filled with real pin levels.
    if (strap_cnt_reg != BEAT_LAST) begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == STRAP_WAIT) begin
        single_next = sync2_reg[P_OMAIN] & sync2_reg[P_OCOMP];
      end
    end
  end

  // State registers but the synchroniser; with no strobe edge only the strap capture, the one-cycle delayed event stage and the output stage still change.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= 4'hF;
      last_reg <= LAST_NONE;
      wr_pend_reg <= 1'b0;
      wr_pend_addr_reg <= ADDR_RST;
      wr_act_reg <= 1'b0;
      wr_addr_reg <= ADDR_RST;
      wr_beat_reg <= BEAT_RST;
      rdp_reg <= 1'b0;
      rdp_addr_reg <= ADDR_RST;
      go_reg <= 1'b0;
      go_addr_reg <= ADDR_RST;
      act_reg <= 1'b0;
      rd_addr_reg <= ADDR_RST;
      rd_beat_reg <= BEAT_RST;
      launch_d_reg <= 1'b0;
      out_evt_d_reg <= 1'b0;
      read_data_reg <= DATA_RST;
      read_data_oe_reg <= 1'b0;
      strap_cnt_reg <= BEAT_RST;
      single_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      last_reg <= last_next;
      wr_pend_reg <= wr_pend_next;
      wr_pend_addr_reg <= wr_pend_addr_next;
      wr_act_reg <= wr_act_next;
      wr_addr_reg <= wr_addr_next;
      wr_beat_reg <= wr_beat_next;
      rdp_reg <= rdp_next;
      rdp_addr_reg <= rdp_addr_next;
      go_reg <= go_next;
      go_addr_reg <= go_addr_next;
      act_reg <= act_next;
      rd_addr_reg <= rd_addr_next;
      rd_beat_reg <= rd_beat_next;
      launch_d_reg <= launch;
      out_evt_d_reg <= out_evt;
      read_data_reg <= read_data_next;
      read_data_oe_reg <= read_data_oe_next;
      strap_cnt_reg <= strap_cnt_next;
      single_reg <= single_next;
    end
  end

  assign read_data = read_data_reg;
  assign read_data_oe = read_data_oe_reg;

  default clocking pc @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_read_armed;
    main_rise && rdp_reg && !act_reg && !go_reg;
  endsequence

  a_rd_repeat_ignored: assert property (
    main_rise && (last_reg == LAST_RD) |-> !rd_start)
    else $error("read started on two consecutive main rises");
  a_wr_repeat_ignored: assert property (
    main_rise && (last_reg == LAST_WR) |-> !wr_start)
    else $error("write started on two consecutive main rises");
  a_arb_read_first: assert property (
    main_rise && (last_reg == LAST_NONE) && !sync2_reg[P_RPS] && !sync2_reg[P_WPS]
    |-> rd_start && !wr_start ##1 last_reg == LAST_RD)
    else $error("read did not win arbitration from deselect");
  a_wr_first_beat: assert property (
    main_rise && wr_pend_reg |-> mif.wr_en && (mif.wr_addr[BEAT_W-1:0] == BEAT_RST))
    else $error("first write beat not captured on the next main rise");
  a_lane_keep_all: assert property (
    mif.wr_en && !sync2_reg[P_ORG] && (&sync2_reg[P_LANE +: 2]) |-> mif.wr_mask == DATA_RST)
    else $error("all lane selects high still wrote data");
  a_dll_off_beat0: assert property (
    s_read_armed and dll_off |-> launch && (mif.rd_addr[BEAT_W-1:0] == BEAT_RST))
    else $error("loop-off read did not launch beat zero at once");
  a_launch_drives: assert property (
    out_evt && launch |-> ##2 read_data_oe)
    else $error("launched read beat not driven two cycles later");
  a_idle_tristate: assert property (
    out_evt && !launch |-> ##2 !read_data_oe)
    else $error("outputs driven after an event with no read beat");
  a_stop_holds: assert property (
    !main_rise && !comp_rise && !out_evt |=> $stable(act_reg) && $stable(rd_beat_reg)
                                           && $stable(wr_beat_reg) && $stable(last_reg))
    else $error("state moved without any strobe edge");
  a_burst_order: assert property (
    launch && act_reg |-> mif.rd_addr == {rd_addr_reg, rd_beat_reg})
    else $error("read beat address out of burst order");

endmodule

// [shared/b4sp_mem_if.sv]
// Purpose: Carrier between the port controller and its storage array.
// Assumes: Write and read ports are used in the same cycle freely.
// Notes:   The mask selects which bits of the word a write replaces.
`timescale 1ns/100ps
interface b4sp_mem_if;
  import b4sp_pkg::*;
  logic              wr_en;
  logic [MEM_AW-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] wr_mask;
  logic              rd_en;
  logic [MEM_AW-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output wr_mask,
                output rd_en, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input wr_mask,
                input rd_en, input rd_addr, output rd_data);
endinterface

// [shared/b4sp_pkg.sv]
// Purpose: Shared constants and types of the burst-of-four separate-I/O SRAM port.
// Assumes: One 50 MHz ref_clk samples every pin; strobe edges come from that sampling.
// Notes:   Bit positions below index the vector of synchronised pin inputs.
package b4sp_pkg;

  // Sizes of the address, burst counter, word address and data path.
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned BEAT_W = 2;
  localparam int unsigned MEM_AW = ADDR_W + BEAT_W;
  localparam int unsigned DATA_W = 18;

  // Layout of the synchronised pin vector.
  localparam int unsigned P_MAIN = 0;
  localparam int unsigned P_COMP = 1;
  localparam int unsigned P_OMAIN = 2;
  localparam int unsigned P_OCOMP = 3;
  localparam int unsigned P_LOOP = 4;
  localparam int unsigned P_ORG = 5;
  localparam int unsigned P_RPS = 6;
  localparam int unsigned P_WPS = 7;
  localparam int unsigned P_ADDR = 8;
  localparam int unsigned P_DATA = P_ADDR + ADDR_W;
  localparam int unsigned P_LANE = P_DATA + DATA_W;
  localparam int unsigned P_NIB = P_LANE + 2;
  localparam int unsigned SYNC_W = P_NIB + 2;

  // Lane widths of the two organisations.
  localparam int unsigned BYTE_W = 9;
  localparam int unsigned NIB_W = 4;

  // Cycles after reset release before the strap pins are trusted.
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // Values after reset, and the index of the last burst beat.
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
  localparam logic [SYNC_W-1:0] SYNC_RST = 36'hFFFFFFFFF;
  localparam logic [BEAT_W-1:0] BEAT_RST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;

  // Kind of operation started on the previous main strobe rise.
  typedef enum logic [1:0] {
    LAST_NONE = 2'b00,
    LAST_RD   = 2'b01,
    LAST_WR   = 2'b10
  } b4sp_last_e;

endpackage

// [verif/b4sp_ctrl_model.sv]
// Purpose: Controller model that plays a schedule of starts and write beats.
// Assumes: One main strobe period is eight ref_clk periods; pins move on negedges.
// Notes:   Pins move mid-phase, so every strobe rise finds selects and data settled.
`timescale 1ns/100ps
module b4sp_ctrl_model
  import b4sp_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              single,
  input  wire logic              org_nibble,
  output logic                   main_strobe,
  output logic                   main_strobe_comp,
  output logic                   out_strobe,
  output logic                   out_strobe_comp,
  output logic                   read_port_select_n,
  output logic                   write_port_select_n,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] write_data,
  output logic      [1:0]        lane_write_select_n,
  output logic      [1:0]        nibble_lane_select_n
);
  logic              rps_q [64];
  logic              wps_q [64];
  logic [ADDR_W-1:0] adr_q [64];
  logic [DATA_W-1:0] dat_q [128];
  logic [1:0]        lan_q [128];
  logic              os_r = 1'b0;
  logic              oc_r = 1'b1;
  int                tick = 0;
  int                rd_tick = -1;

  // Both output strobes high at power-on ask for single-strobe timing.
  assign out_strobe      = os_r | single;
  assign out_strobe_comp = oc_r | single;

  // Idle slots carry changing junk with every lane enabled; none of it may be stored.
  task automatic clear();
    rd_tick = -1;
    for (int i = 0; i < 128; i++) begin
      dat_q[i] = DATA_W'(i * 7919);
      lan_q[i] = 2'h0;
    end
    for (int i = 0; i < 64; i++) begin
      rps_q[i] = 1'b1;
      wps_q[i] = 1'b1;
      adr_q[i] = ADDR_W'(i);
    end
  endtask

  // A write start carries its four beats on the next two main and comp rises.
  task automatic sched(input int k, input logic rd, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d [4], input logic [1:0] ln [4]);
    adr_q[k] = a;
    if (rd) begin
      rps_q[k] = 1'b0;
    end else begin
      wps_q[k] = 1'b0;
      for (int i = 0; i < 4; i++) begin
        dat_q[2*k+2+i] = d[i];
        lan_q[2*k+2+i] = ln[i];
      end
    end
  endtask

  // The lane pins of the unused organisation get the inverse, so a wrong pick shows.
  task automatic put(input int i);
    write_data           = dat_q[i];
    lane_write_select_n  = org_nibble ? ~lan_q[i] : lan_q[i];
    nibble_lane_select_n = org_nibble ? lan_q[i] : ~lan_q[i];
  endtask

  // Stopped strobes: every pin simply stands where it was.
  task automatic pause(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Per period: main rise, comp beat, comp rise, then next start and main beat.
  task automatic play(input int k0, input int k1);
    // Period k0 has no earlier period to set its selects, so present them before its rise.
    read_port_select_n  = rps_q[k0];
    write_port_select_n = wps_q[k0];
    addr                = adr_q[k0];
    put(2*k0);
    for (int k = k0; k <= k1; k++) begin
      for (int ph = 0; ph < 4; ph++) begin
        @(negedge ref_clk);
        tick++;
        case (ph)
          0: begin
            main_strobe      = 1'b1;
            main_strobe_comp = 1'b0;
            if (!rps_q[k] && rd_tick < 0) rd_tick = tick;
          end
          1: begin
            put(2*k+1);
            os_r = 1'b1;
            oc_r = 1'b0;
          end
          2: begin
            main_strobe      = 1'b0;
            main_strobe_comp = 1'b1;
          end
          default: begin
            read_port_select_n  = rps_q[k+1];
            write_port_select_n = wps_q[k+1];
            addr                = adr_q[k+1];
            put(2*k+2);
            os_r = 1'b0;
            oc_r = 1'b1;
          end
        endcase
        @(negedge ref_clk);
        tick++;
      end
    end
  endtask

  // Start deselected with strobes still until a schedule is played.
  initial begin
    main_strobe         = 1'b0;
    main_strobe_comp    = 1'b1;
    read_port_select_n  = 1'b1;
    write_port_select_n = 1'b1;
    addr                = ADDR_RST;
    clear();
    put(0);
  end
endmodule

// [verif/testbench.sv]
// Purpose: Self-checking bench for the burst-of-four SRAM port.
// Assumes: The controller model plays schedules; reads are judged at the read pins.
// Notes:   Read beats are sampled seven edges after each output timing edge.
`timescale 1ns/100ps
module testbench
  import b4sp_pkg::*;
();
  typedef struct {int t; logic [DATA_W-1:0] d;} b4sp_beat_s;
  logic              ref_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              single = 1'b0;
  logic              org_nibble = 1'b0;
  logic              loop_disable_n = 1'b1;
  wire logic         main_strobe, main_strobe_comp, out_strobe, out_strobe_comp;
  wire logic         read_port_select_n, write_port_select_n, read_data_oe;
  wire logic [ADDR_W-1:0] addr;
  wire logic [DATA_W-1:0] write_data, read_data;
  wire logic [1:0]   lane_write_select_n, nibble_lane_select_n;
  logic [DATA_W-1:0] mem_x [256];
  logic [DATA_W-1:0] exp_d [$];
  logic [DATA_W-1:0] exp_m [$];
  b4sp_beat_s        got [$];
  logic [1:0]        on4 [4] = '{default: 2'h0};
  logic [1:0]        mix [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic [1:0]        sel;
  logic [1:0]        sel_d = 2'h3;
  logic [5:0]        sr = 6'h00;
  int                bad_count = 0;
  int                checks_done = 0;

  b4sp_ctrl_model i_b4sp_ctrl_model (.ref_clk, .single, .org_nibble, .main_strobe,
    .main_strobe_comp, .out_strobe, .out_strobe_comp, .read_port_select_n,
    .write_port_select_n, .addr, .write_data, .lane_write_select_n, .nibble_lane_select_n);
  b4sp_port i_b4sp_port (.ref_clk, .rst_b, .main_strobe, .main_strobe_comp, .out_strobe,
    .out_strobe_comp, .loop_disable_n, .org_nibble, .read_port_select_n,
    .write_port_select_n, .addr, .write_data, .lane_write_select_n, .nibble_lane_select_n,
    .read_data, .read_data_oe);

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // Sample read beats once they have settled, only while the outputs are driven.
  always @(posedge ref_clk) begin
    sel = (single || !loop_disable_n) ? {main_strobe, main_strobe_comp}
                                      : {out_strobe, out_strobe_comp};
    sel_d <= sel;
    sr <= {sr[4:0], |(sel & ~sel_d)};
    if (sr[5] && read_data_oe === 1'b1) begin
      got.push_back('{i_b4sp_ctrl_model.tick, read_data});
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    repeat (4) @(negedge ref_clk);
    rst_b = 1'b1;
    i_b4sp_ctrl_model.pause(8);
    check("oe after reset", read_data_oe, 1'b0);
    check("data after reset", read_data, DATA_RST);
  endtask

  // Bits that a beat with these active-low lane selects replaces.
  function automatic logic [DATA_W-1:0] keep(input logic [1:0] ln);
    keep = '0;
    if (!ln[0]) keep |= org_nibble ? 18'h0000F : 18'h001FF;
    if (!ln[1]) keep |= org_nibble ? 18'h000F0 : 18'h3FE00;
  endfunction

  task automatic wr(input int k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] s,
                    input logic [1:0] ln [4]);
    logic [DATA_W-1:0] d [4];
    logic [DATA_W-1:0] m;
    for (int i = 0; i < 4; i++) begin
      d[i] = s ^ (18'h0C30C << i);
      m = keep(ln[i]);
      mem_x[{a, BEAT_W'(i)}] = (mem_x[{a, BEAT_W'(i)}] & ~m) | (d[i] & m);
    end
    i_b4sp_ctrl_model.sched(k, 1'b0, a, d, ln);
  endtask

  // Expected beats are snapshots taken in schedule order, so later writes do not leak.
  task automatic rd(input int k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m);
    logic [DATA_W-1:0] d [4];
    for (int i = 0; i < 4; i++) begin
      exp_d.push_back(mem_x[{a, BEAT_W'(i)}] & m);
      exp_m.push_back(m);
    end
    i_b4sp_ctrl_model.sched(k, 1'b1, a, d, on4);
  endtask

  // Beats come in order, one per output timing edge, after the set latency.
  task automatic go(input int k0, input int k1, input int delta);
    i_b4sp_ctrl_model.play(k0, k1);
    check("beat count", got.size(), exp_d.size());
    for (int i = 0; i < got.size() && i < exp_d.size(); i++) begin
      check("beat data", got[i].d & exp_m[i], exp_d[i]);
      check("beat time", got[i].t - i_b4sp_ctrl_model.rd_tick, delta + 6 + 4 * i);
    end
    check("outputs off", read_data_oe, 1'b0);
    got.delete();
    exp_d.delete();
    exp_m.delete();
  endtask

  task automatic t_burst();
    i_b4sp_ctrl_model.clear();
    wr(1, 6'h3F, 18'h2D1C3, on4);
    wr(3, 6'h00, 18'h15A5A, on4);
    rd(6, 6'h3F, 18'h3FFFF);
    go(1, 14, 14);
  endtask

  task automatic t_lanes(input logic nib);
    org_nibble = nib;
    i_b4sp_ctrl_model.clear();
    wr(1, 6'h05, 18'h3C3C3, on4);
    wr(3, 6'h05, 18'h0A5A5, mix);
    rd(6, 6'h05, nib ? 18'h000FF : 18'h3FFFF);
    go(1, 14, 14);
    org_nibble = 1'b0;
  endtask

  // Second write and second read on consecutive rises must both be dropped.
  task automatic t_b2b();
    i_b4sp_ctrl_model.clear();
    wr(1, 6'h08, 18'h12345, on4);
    wr(3, 6'h07, 18'h2BCDE, on4);
    i_b4sp_ctrl_model.wps_q[4] = 1'b0;
    i_b4sp_ctrl_model.adr_q[4] = 6'h08;
    rd(6, 6'h08, 18'h3FFFF);
    i_b4sp_ctrl_model.rps_q[7] = 1'b0;
    go(1, 16, 14);
  endtask

  // Both selects low from deselect: read, write, read; the last read sees the write.
  task automatic t_both();
    i_b4sp_ctrl_model.clear();
    wr(1, 6'h09, 18'h0F0F0, on4);
    rd(4, 6'h09, 18'h3FFFF);
    wr(5, 6'h09, 18'h30303, on4);
    rd(6, 6'h09, 18'h3FFFF);
    i_b4sp_ctrl_model.wps_q[4] = 1'b0;
    i_b4sp_ctrl_model.rps_q[5] = 1'b0;
    i_b4sp_ctrl_model.wps_q[6] = 1'b0;
    go(1, 16, 14);
  endtask

  task automatic t_stop();
    i_b4sp_ctrl_model.clear();
    wr(1, 6'h2A, 18'h1E1E1, on4);
    rd(4, 6'h2A, 18'h3FFFF);
    i_b4sp_ctrl_model.play(1, 2);
    i_b4sp_ctrl_model.pause(40);
    go(3, 12, 14);
  endtask

  task automatic t_timing();
    loop_disable_n = 1'b0;
    i_b4sp_ctrl_model.clear();
    rd(2, 6'h3F, 18'h3FFFF);
    go(1, 8, 8);
    loop_disable_n = 1'b1;
    single = 1'b1;
    do_reset();
    i_b4sp_ctrl_model.clear();
    rd(2, 6'h3F, 18'h3FFFF);
    go(1, 8, 12);
  endtask

  initial begin
    do_reset();
    i_b4sp_ctrl_model.clear();
    go(1, 6, 14);
    t_burst();
    t_lanes(1'b0);
    t_lanes(1'b1);
    t_b2b();
    t_both();
    t_stop();
    t_timing();
    final_report();
  end

  // All scenarios need some 930 ref_clk periods; far beyond that means a hang.
  initial begin
    repeat (30000) @(posedge ref_clk);
    bad_count++;
    final_report();
  end
endmodule
